// ### lkeq_config.sv
// Purpose: I2C register bank and channel settings selection
// Assumes: SCL and SDA asynchronous pins, sampled at 100 MHz
// Notes: block transfers only, pointer restarts at zero each transfer
`timescale 1ns/1ps
module lkeq_config #(
   parameter int POLL_CYCLES = lkeq_pkg::LKEQ_POLL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_strap_upper,
   input wire logic addr_strap_mid,
   input wire logic addr_strap_low,
   input wire logic power_on_input,
   input wire logic strap_mode,
   input wire logic [3:0] eq_boost_strap,
   input wire logic swing_strap_high,
   input wire logic [1:0] emphasis_strap,
   input wire logic [3:0] load_seen,
   output logic [15:0] eq_boost_select,
   output logic [7:0] emphasis_cut_select,
   output logic [3:0] swing_select_high,
   output logic [3:0] swing_select_low,
   output logic [3:0] channel_active,
   output logic [3:0] out_term_strong,
   output logic [3:0] in_term_strong,
   output logic [3:0] load_check
);
   import lkeq_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] scl_sync, sda_sync, pen_sync, mode_sync;
   logic [1:0] a4_sync, a1_sync, a0_sync;
   logic [3:0] bst_s1, bst_s2;
   logic vodh_s1, vodh_s2;
   logic [1:0] de_s1, de_s2;
   logic scl_prev, sda_prev;
   // Comparator outputs change on their own time, so they are synchronised too
   logic [3:0] load_s1, load_s2;

   // Two flops each; first stage read only by the second
   always_ff @(posedge clk)
   begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      pen_sync <= {pen_sync[0], power_on_input};
      mode_sync <= {mode_sync[0], strap_mode};
      a4_sync <= {a4_sync[0], addr_strap_upper};
      a1_sync <= {a1_sync[0], addr_strap_mid};
      a0_sync <= {a0_sync[0], addr_strap_low};
      bst_s1 <= eq_boost_strap;
      bst_s2 <= bst_s1;
      vodh_s1 <= swing_strap_high;
      vodh_s2 <= vodh_s1;
      de_s1 <= emphasis_strap;
      de_s2 <= de_s1;
      load_s1 <= load_seen;
      load_s2 <= load_s1;
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
   end

   logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   assign scl_rise = scl_s && !scl_prev;
   assign scl_fall = !scl_s && scl_prev;
   assign start_cond = scl_s && scl_prev && sda_prev && !sda_s;
   assign stop_cond = scl_s && scl_prev && !sda_prev && sda_s;

   // ------------------------------------------------------------
   // Strap latch after reset release
   // ------------------------------------------------------------
   // Straps settle through synchronisers before the bank loads them
   logic [1:0] boot_cnt_reg;
   logic boot_load;
   always_ff @(posedge clk)
   begin
      if (rst)
         boot_cnt_reg <= 2'h0;
      else if (boot_cnt_reg != 2'h3)
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
   end
   assign boot_load = (boot_cnt_reg == 2'h2);

   // ------------------------------------------------------------
   // Target engine
   // ------------------------------------------------------------
   typedef enum {LKEQ_IDLE, LKEQ_ADDR, LKEQ_ACK, LKEQ_WDATA, LKEQ_RDATA, LKEQ_RACK}
      lkeq_state_t;
   lkeq_state_t state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic read_reg;
   logic addr_ok;
   logic [3:0] ptr_reg;
   logic first_wr_reg;
   logic wr_strobe;
   logic [7:0] rd_byte;
   logic [6:0] my_addr;
   logic wr_pending_reg;

   // Address bits from straps
   assign my_addr = {LKEQ_ADDR_TOP, a4_sync[1], LKEQ_ADDR_GAP, a1_sync[1], a0_sync[1]};
   // Address sits above the direction bit once eight bits are in
   assign addr_ok = (shift_reg[7:1] == my_addr);

   // Byte collection, acknowledge and transfer direction
   always_ff @(posedge clk)
   begin
      if (rst || stop_cond)
      begin
         state_reg <= LKEQ_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg <= LKEQ_ZERO_BYTE;
         read_reg <= 1'b0;
      end
      else if (start_cond)
      begin
         state_reg <= LKEQ_ADDR;
         bit_cnt_reg <= 3'h0;
      end
      else
      begin
         case (state_reg)
            LKEQ_ADDR, LKEQ_WDATA:
               if (scl_rise)
               begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
               end
               else if (scl_fall && bit_cnt_reg == 3'h0 && shift_reg != LKEQ_ZERO_BYTE
                        && state_reg == LKEQ_ADDR)
               begin
                  if (addr_ok)
                  begin
                     read_reg <= (shift_reg[0] == LKEQ_RW_READ);
                     state_reg <= LKEQ_ACK;
                  end
                  else
                     state_reg <= LKEQ_IDLE;
               end
               else if (scl_fall && bit_cnt_reg == 3'h0 && state_reg == LKEQ_WDATA
                        && wr_pending_reg)
                  state_reg <= LKEQ_ACK;
            LKEQ_ACK:
               if (scl_fall)
               begin
                  bit_cnt_reg <= 3'h0;
                  shift_reg <= LKEQ_ZERO_BYTE;
                  state_reg <= read_reg ? LKEQ_RDATA : LKEQ_WDATA;
               end
            LKEQ_RDATA:
               if (scl_fall)
               begin
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == 3'h7)
                     state_reg <= LKEQ_RACK;
               end
            LKEQ_RACK:
               if (scl_rise)
                  state_reg <= sda_s ? LKEQ_IDLE : LKEQ_RACK; // Host nack ends read
               else if (scl_fall)
                  state_reg <= LKEQ_RDATA;
            default:
               state_reg <= LKEQ_IDLE;
         endcase
      end
   end

   // Marks a full data byte received; cleared once acknowledged
   always_ff @(posedge clk)
   begin
      if (rst || start_cond || stop_cond)
         wr_pending_reg <= 1'b0;
      else if (state_reg == LKEQ_WDATA && scl_rise && bit_cnt_reg == 3'h7)
         wr_pending_reg <= 1'b1;
      else if (state_reg == LKEQ_ACK)
         wr_pending_reg <= 1'b0;
   end
   assign wr_strobe = (state_reg == LKEQ_WDATA) && scl_fall && wr_pending_reg;

   // Byte pointer; each transfer starts at the lowest byte
   always_ff @(posedge clk)
   begin
      if (rst || start_cond)
      begin
         ptr_reg <= LKEQ_REG_RSVD0;
         first_wr_reg <= 1'b1;
      end
      else if (wr_strobe)
      begin
         first_wr_reg <= 1'b0;
         // Offset byte is a dummy and never moves the pointer
         if (!first_wr_reg)
            ptr_reg <= ptr_reg + 4'h1;
      end
      else if (state_reg == LKEQ_RACK && scl_fall)
         ptr_reg <= ptr_reg + 4'h1;
   end

   // ------------------------------------------------------------
   // Register bank
   // ------------------------------------------------------------
   logic [3:0] enables_reg;
   logic [7:0] eq10_reg, eq32_reg, swing_reg, deemph_reg;
   logic reg_we;
   assign reg_we = wr_strobe && !first_wr_reg;

   // Loads from latched straps; only bytes 2 to 6 take writes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         enables_reg <= LKEQ_ENABLE_LOW_RESET;
         eq10_reg <= LKEQ_ZERO_BYTE;
         eq32_reg <= LKEQ_ZERO_BYTE;
         swing_reg <= LKEQ_ZERO_BYTE;
         deemph_reg <= LKEQ_ZERO_BYTE;
      end
      else if (boot_load)
      begin
         enables_reg <= {4{pen_sync[1]}};
         eq10_reg <= {bst_s2, bst_s2};
         eq32_reg <= {bst_s2, bst_s2};
         swing_reg <= {4{vodh_s2, LKEQ_SWING_LOW_RESET}};
         deemph_reg <= {4{de_s2}};
      end
      else if (reg_we)
      begin
         case (ptr_reg)
            LKEQ_REG_ENABLES: enables_reg <= shift_reg[7:LKEQ_ENABLE_LSB];
            LKEQ_REG_EQ10: eq10_reg <= shift_reg;
            LKEQ_REG_EQ32: eq32_reg <= shift_reg;
            LKEQ_REG_SWING: swing_reg <= shift_reg;
            LKEQ_REG_DEEMPH: deemph_reg <= shift_reg;
            default: enables_reg <= enables_reg; // Reserved or read-only
         endcase
      end
   end

   // Read data; reserved and unused bytes read zero
   always_comb
   begin
      case (ptr_reg)
         LKEQ_REG_ENABLES: rd_byte = {enables_reg, LKEQ_ENABLE_LOW_RESET};
         LKEQ_REG_EQ10: rd_byte = eq10_reg;
         LKEQ_REG_EQ32: rd_byte = eq32_reg;
         LKEQ_REG_SWING: rd_byte = swing_reg;
         LKEQ_REG_DEEMPH: rd_byte = deemph_reg;
         default: rd_byte = LKEQ_ZERO_BYTE;
      endcase
   end

   // SDA drive: ack low, or read bits MSB first
   always_ff @(posedge clk)
   begin
      if (rst)
         sda_oe <= 1'b0;
      else if (state_reg == LKEQ_ACK)
         sda_oe <= 1'b1;
      else if (state_reg == LKEQ_RDATA)
         sda_oe <= !rd_byte[3'h7 - bit_cnt_reg];
      else
         sda_oe <= 1'b0;
   end
   assign sda_out = 1'b0;

   // ------------------------------------------------------------
   // Channel settings selection
   // ------------------------------------------------------------
   logic power_on;
   logic pen_prev;
   logic restart;
   assign power_on = pen_sync[1];

   // Rising power enable restarts detection with weak terminations
   always_ff @(posedge clk)
   begin
      if (rst)
         pen_prev <= 1'b0;
      else
         pen_prev <= power_on;
   end
   assign restart = power_on && !pen_prev;

   // Settings registered so data outputs come from flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         eq_boost_select <= 16'h0000;
         emphasis_cut_select <= 8'h00;
         swing_select_high <= 4'h0;
         swing_select_low <= 4'h0;
         channel_active <= 4'h0;
      end
      else if (mode_sync[1])
      begin
         eq_boost_select <= {4{bst_s2}};
         emphasis_cut_select <= {4{de_s2}};
         swing_select_high <= {4{vodh_s2}};
         swing_select_low <= {4{LKEQ_SWING_LOW_RESET}};
         channel_active <= {4{power_on}};
      end
      else
      begin
         eq_boost_select <= {eq32_reg, eq10_reg};
         emphasis_cut_select <= deemph_reg;
         swing_select_high <= {swing_reg[7], swing_reg[5], swing_reg[3], swing_reg[1]};
         swing_select_low <= {swing_reg[6], swing_reg[4], swing_reg[2], swing_reg[0]};
         channel_active <= enables_reg & {4{power_on}};
      end
   end

   // ------------------------------------------------------------
   // Load polling per channel
   // ------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < LKEQ_CHANNELS; ch++)
      begin : g_poll
         lkeq_load_poll #(.POLL_CYCLES(POLL_CYCLES)) u_poll (
            .clk(clk),
            .rst(rst),
            .restart(restart),
            .active(channel_active[ch]),
            .load_seen(load_s2[ch]),
            .strong_term(out_term_strong[ch]),
            .check_pulse(load_check[ch])
         );
      end
   endgenerate

   // Input termination strong only when the output load is found
   assign in_term_strong = out_term_strong;
endmodule

// ### lkeq_config_monitor.sv
// Purpose: port checks for lkeq_config
// Assumes: one clock, sync active high reset
// Notes: strap and power checks allow for the pin synchronisers
`timescale 1ns/1ps
module lkeq_config_monitor #(
   parameter int POLL_CYCLES = lkeq_pkg::LKEQ_POLL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic power_on_input,
   input wire logic strap_mode,
   input wire logic [3:0] eq_boost_strap,
   input wire logic swing_strap_high,
   input wire logic [1:0] emphasis_strap,
   input wire logic [3:0] load_seen,
   input wire logic [15:0] eq_boost_select,
   input wire logic [7:0] emphasis_cut_select,
   input wire logic [3:0] swing_select_high,
   input wire logic [3:0] swing_select_low,
   input wire logic [3:0] channel_active,
   input wire logic [3:0] out_term_strong,
   input wire logic [3:0] in_term_strong,
   input wire logic [3:0] load_check
);
   import lkeq_pkg::*;
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Eight cycles cover synchronisers plus output register
   sequence s_off;
      !power_on_input [*8];
   endsequence
   sequence s_straps;
      (strap_mode && power_on_input &&
         $stable({eq_boost_strap, emphasis_strap, swing_strap_high})) [*8];
   endsequence
   property p_reset_quiet;
      $fell(rst) |-> channel_active == 4'h0 && out_term_strong == 4'h0 && !sda_oe;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live after reset");
   property p_open_drain;
      sda_oe |-> !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda driven high");
   property p_term_pair;
      in_term_strong == out_term_strong &&
         (out_term_strong & ~$past(channel_active)) == 4'h0;
   endproperty
   a_term_pair: assert property (p_term_pair) else $error("strong termination on idle channel");
   property p_off;
      s_off |-> channel_active == 4'h0 && out_term_strong == 4'h0;
   endproperty
   a_off: assert property (p_off) else $error("active while powered down");
   property p_strap_eq;
      s_straps |-> eq_boost_select == {4{eq_boost_strap}} &&
         emphasis_cut_select == {4{emphasis_strap}};
   endproperty
   a_strap_eq: assert property (p_strap_eq) else $error("strap boost or emphasis lost");
   property p_strap_swing;
      s_straps |-> swing_select_high == {4{swing_strap_high}} &&
         swing_select_low == 4'hF && channel_active == 4'hF;
   endproperty
   a_strap_swing: assert property (p_strap_swing) else $error("strap swing lost");
   property p_check_pulse;
      load_check[0] |=> !load_check[0];
   endproperty
   a_check_pulse: assert property (p_check_pulse) else $error("poll pulse too long");
   property p_found;
      $rose(out_term_strong[0]) |-> $past(load_seen[0], 3) && $past(channel_active[0]);
   endproperty
   a_found: assert property (p_found) else $error("load found without cause");
endmodule
bind lkeq_config lkeq_config_monitor #(.POLL_CYCLES(POLL_CYCLES)) u_mon (.clk, .rst, .sda_out,
   .sda_oe, .power_on_input, .strap_mode, .eq_boost_strap, .swing_strap_high, .emphasis_strap,
   .load_seen, .eq_boost_select, .emphasis_cut_select, .swing_select_high, .swing_select_low,
   .channel_active, .out_term_strong, .in_term_strong, .load_check);

// ### lkeq_config_tb.sv
// Purpose: self-checking bench for lkeq_config
// Assumes: short poll window, host model on the I2C pins
// Notes: seeded random data with fixed code sweeps
`timescale 1ns/1ps
module lkeq_config_tb;
   import lkeq_pkg::*;
   localparam int POLL = 50;
   logic clk, rst, scl_in, sda_in, host_low, sda_out, sda_oe, ok, ack;
   logic addr_strap_upper, addr_strap_mid, addr_strap_low, power_on_input, strap_mode;
   logic swing_strap_high;
   logic [1:0] emphasis_strap;
   logic [3:0] eq_boost_strap, load_seen, swing_select_high, swing_select_low;
   logic [3:0] channel_active, out_term_strong, in_term_strong, load_check;
   logic [15:0] eq_boost_select;
   logic [7:0] emphasis_cut_select, q;
   logic [7:0] wr [7];
   logic [7:0] rd [7];
   logic [6:0] dev;
   int fails, comparisons, pulses;
   // Pull-up wire: low when either party pulls
   assign sda_in = !(host_low || (sda_oe && !sda_out));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   lkeq_i2c_host host (.clk, .sda_wire(sda_in), .scl(scl_in), .sda_low(host_low));
   lkeq_config #(.POLL_CYCLES(POLL)) dut (.clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
      .addr_strap_upper, .addr_strap_mid, .addr_strap_low, .power_on_input, .strap_mode,
      .eq_boost_strap, .swing_strap_high, .emphasis_strap, .load_seen, .eq_boost_select,
      .emphasis_cut_select, .swing_select_high, .swing_select_low, .channel_active,
      .out_term_strong, .in_term_strong, .load_check);
   // -------
   // Helpers
   // -------
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // A refused address ends the transfer at once
   task automatic rd_block(input logic [6:0] a);
      host.start_cond();
      host.byte_io({a, LKEQ_RW_READ}, 1'b1, q, ack);
      ok = !ack;
      for (int i = 0; i < 7 && ok; i++)
         host.byte_io(8'hFF, i == 6, rd[i], ack);
      host.stop_cond();
   endtask
   task automatic wr_block(input logic [7:0] dummy);
      host.start_cond();
      host.byte_io({dev, !LKEQ_RW_READ}, 1'b1, q, ack);
      check("write address ack", 1'b0, ack);
      host.byte_io(dummy, 1'b1, q, ack);
      check("dummy ack", 1'b0, ack);
      for (int i = 0; i < 7; i++)
      begin
         host.byte_io(wr[i], 1'b1, q, ack);
         check("data ack", 1'b0, ack);
      end
      host.stop_cond();
   endtask
   function automatic logic [7:0] boot_val(int i);
      case (i)
         2: return {{4{power_on_input}}, LKEQ_ENABLE_LOW_RESET};
         3, 4: return {eq_boost_strap, eq_boost_strap};
         5: return {4{swing_strap_high, LKEQ_SWING_LOW_RESET}};
         6: return {4{emphasis_strap}};
         default: return LKEQ_ZERO_BYTE;
      endcase
   endfunction
   function automatic logic [7:0] post_val(int i);
      if (i == 2)
         return {wr[2][7:4], LKEQ_ENABLE_LOW_RESET};
      return i > 2 ? wr[i] : LKEQ_ZERO_BYTE;
   endfunction
   function automatic logic [3:0] pick(logic [7:0] b, int o);
      return {b[6 + o], b[4 + o], b[2 + o], b[o]};
   endfunction
   // Hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      fails++;
      $display("CHECK FAILED run length expected finish seen timeout");
      conclude();
   end
   // Main sequence
   initial
   begin
      void'($urandom(32'hC12F));
      rst = 1'b1;
      {addr_strap_upper, addr_strap_mid, addr_strap_low} = 3'($urandom);
      {power_on_input, swing_strap_high, emphasis_strap, eq_boost_strap} = 8'($urandom);
      strap_mode = 1'b0;
      load_seen = 4'h0;
      fails = 0;
      comparisons = 0;
      settle(10);
      rst = 1'b0;
      settle(20);
      dev = {LKEQ_ADDR_TOP, addr_strap_upper, LKEQ_ADDR_GAP, addr_strap_mid, addr_strap_low};
      rd_block(dev);
      check("read address ack", 1'b1, ok);
      for (int i = 1; i < 7; i++)
         check($sformatf("boot %0d", i), boot_val(i), rd[i]);
      // Any one address bit wrong must go unanswered
      for (int k = 0; k < 7; k++)
      begin
         rd_block(dev ^ (7'h01 << k));
         check("foreign ack", 1'b0, ok);
      end
      // Sweep all boost, emphasis and swing codes through the bank
      power_on_input = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         foreach (wr[i])
            wr[i] = 8'($urandom);
         wr[3] = {4'(4 * k + 1), 4'(4 * k)};
         wr[4] = {4'(4 * k + 3), 4'(4 * k + 2)};
         wr[5] = {4{2'(k)}};
         wr[6] = {4{2'(3 - k)}};
         wr_block(8'($urandom));
         rd_block(dev);
         for (int i = 1; i < 7; i++)
            check($sformatf("byte %0d", i), post_val(i), rd[i]);
         check("boost", {wr[4], wr[3]}, eq_boost_select);
         check("emphasis", wr[6], emphasis_cut_select);
         check("swing high", pick(wr[5], 1), swing_select_high);
         check("swing low", pick(wr[5], 0), swing_select_low);
         check("enables", wr[2][7:4], channel_active);
      end
      strap_mode = 1'b1;
      settle(10);
      check("strap boost", {4{eq_boost_strap}}, eq_boost_select);
      check("strap emphasis", {4{emphasis_strap}}, emphasis_cut_select);
      check("strap swing", {4{swing_strap_high}}, swing_select_high);
      check("strap low", 4'hF, swing_select_low);
      strap_mode = 1'b0;
      // Load polling, power cycling and channel disable
      wr[2] = 8'hF0;
      wr_block(8'h00);
      load_seen = 4'h5;
      settle(2 * POLL + 10);
      check("load found", 4'h5, out_term_strong);
      check("input term", 4'h5, in_term_strong);
      pulses = 0;
      repeat (5 * POLL)
      begin
         @(posedge clk);
         #1;
         pulses += int'(load_check[1] === 1'b1);
      end
      check("poll pulses", 16'h0005, 16'(pulses));
      power_on_input = 1'b0;
      settle(10);
      check("off active", 4'h0, channel_active);
      check("off term", 4'h0, out_term_strong);
      power_on_input = 1'b1;
      settle(10);
      check("wake term", 4'h0, out_term_strong);
      check("wake active", 4'hF, channel_active);
      load_seen = 4'h0;
      settle(3 * POLL);
      check("no load", 4'h0, out_term_strong);
      load_seen = 4'hA;
      settle(2 * POLL + 10);
      check("late load", 4'hA, out_term_strong);
      wr[2] = 8'h30;
      wr_block(8'h00);
      check("disabled term", 4'h2, out_term_strong);
      conclude();
   end
endmodule

// ### lkeq_i2c_host.sv
// Purpose: I2C host model for block transfers
// Assumes: bench resolves open-drain SDA with a pull-up
// Notes: SCL low and high phases stay above five clocks
`timescale 1ns/1ps
module lkeq_i2c_host (
   input wire logic clk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_low
);
   localparam int HALF = 8;
   // Idle: both lines released
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic pause(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // No offset phase: every transfer opens at byte zero
   task automatic start_cond();
      sda_low = 1'b1;
      pause(HALF);
      scl = 1'b0;
      pause(2);
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      pause(HALF);
      scl = 1'b1;
      pause(HALF);
      sda_low = 1'b0;
      pause(HALF);
   endtask
   // Data changes only while SCL is low, sampled late in the high phase
   task automatic bit_io(input logic o, output logic i);
      sda_low = !o;
      pause(HALF);
      scl = 1'b1;
      pause(HALF);
      i = sda_wire;
      scl = 1'b0;
      pause(2);
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] d, input logic ack_out, output logic [7:0] q,
      output logic ack_in);
      for (int b = 7; b >= 0; b--)
         bit_io(d[b], q[b]);
      bit_io(ack_out, ack_in);
   endtask
endmodule

// ### lkeq_load_poll.sv
// Purpose: per-channel output load detect polling
// Assumes: load_seen comes from analog comparator, already synchronised
// Notes: one instance per channel; restart clears the found state
`timescale 1ns/1ps
module lkeq_load_poll #(
   parameter int POLL_CYCLES = lkeq_pkg::LKEQ_POLL_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic active,
   input wire logic load_seen,
   output logic strong_term,
   output logic check_pulse
);
   import lkeq_pkg::*;
   logic [31:0] count_reg;
   logic found_reg;

   // ------------------------------------------------------------
   // Detection window timer
   // ------------------------------------------------------------
   // Window restarts on power-up or power enable; sampled at window end
   always_ff @(posedge clk)
   begin
      if (rst || restart || !active)
      begin
         count_reg <= 32'h00000000;
         check_pulse <= 1'b0;
      end
      else if (!found_reg && count_reg == 32'(POLL_CYCLES - 1))
      begin
         count_reg <= 32'h00000000; // Repeat every window
         check_pulse <= 1'b1;
      end
      else
      begin
         count_reg <= found_reg ? count_reg : count_reg + 32'h00000001;
         check_pulse <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Found state
   // ------------------------------------------------------------
   // Weak termination until a load is seen at a window end
   always_ff @(posedge clk)
   begin
      if (rst || restart || !active)
         found_reg <= 1'b0;
      else if (!found_reg && count_reg == 32'(POLL_CYCLES - 1) && load_seen)
         found_reg <= 1'b1;
   end

   assign strong_term = found_reg;
endmodule

// ### lkeq_pkg.sv
// Purpose: constants for the signal conditioner configuration block
// Assumes: 100 MHz system clock, I2C target on sampled pins
// Notes: register bank holds sixteen byte slots, five implemented
// Operation
// - Power-up or power enable rising selects weak 2K out, 200K in terminations.
// - Each channel polls for 50 ohm output load every 5ms until found.
// - Power enable low, pin or register, forces power-down with weak terminations.
// - Byte 2 bits 7:4 enable channels 3:0, start from latched power enable.
// - Four-bit boost code selects sixteen monotonic equalization steps.
// - Two-bit de-emphasis code selects 0, -0.5, -0.7, -1.0 dB.
// - Two-bit swing code, high and low bit, selects four output swings.
// - Target address is 1,1,A4,0,0,A1,A0 then read/write bit.
// - Byte 0 and bytes 7 to F reserved; byte 1 reads zero.
// - Bytes 3 and 4 hold per-channel boost codes from latched straps.
// - Byte 5 holds swing codes; high from strap, low starts at one.
// - Byte 6 holds per-channel de-emphasis codes from latched straps.
// - Only block reads and writes starting from the lowest byte.
// - A write's second byte is a dummy offset and is discarded.
// - Strap mode high uses pin straps for all channels, else registers.
package lkeq_pkg;
   localparam int LKEQ_CHANNELS = 4;
   localparam logic [3:0] LKEQ_REG_RSVD0 = 4'h0;
   localparam logic [3:0] LKEQ_REG_UNUSED = 4'h1;
   localparam logic [3:0] LKEQ_REG_ENABLES = 4'h2;
   localparam logic [3:0] LKEQ_REG_EQ10 = 4'h3;
   localparam logic [3:0] LKEQ_REG_EQ32 = 4'h4;
   localparam logic [3:0] LKEQ_REG_SWING = 4'h5;
   localparam logic [3:0] LKEQ_REG_DEEMPH = 4'h6;
   localparam int LKEQ_ENABLE_LSB = 4;
   localparam logic [3:0] LKEQ_ENABLE_LOW_RESET = 4'h0;
   localparam logic LKEQ_SWING_LOW_RESET = 1'b1;
   localparam logic [1:0] LKEQ_ADDR_TOP = 2'b11;
   localparam logic [1:0] LKEQ_ADDR_GAP = 2'b00;
   localparam logic LKEQ_RW_READ = 1'b1;
   localparam int LKEQ_CLK_MHZ = 100;
   localparam int LKEQ_POLL_MS = 5;
   localparam int LKEQ_POLL_CYCLES = LKEQ_POLL_MS * 1000 * LKEQ_CLK_MHZ;
   localparam logic [7:0] LKEQ_ZERO_BYTE = 8'h00;
endpackage
